// ### bench/pbq_mac_model.sv
// Transmit engine model answering each start with a completion report
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module pbq_mac_model
  import pbq_pkg::*;
#(
  parameter int DLY = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic tx_start,
  input wire logic fatal,
  output pbq_txdone_t tx_done
);
  int cnt = 0;
  initial tx_done = '0;
  always @(negedge clk) begin
    tx_done = '0;
    if (rst) begin
      cnt = 0;
    end else if (tx_start === 1'b1) begin
      cnt = DLY;
    end else if (cnt > 0) begin
      cnt--;
      if (cnt == 0) begin
        tx_done = '{1'b1, fatal, 16'h5a5a};
      end
    end
  end
endmodule

// ### bench/tb_top.sv
// Testbench for the packet buffer queue manager
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %s exp %0h got %0h", n, e, g); end end
`define WAITF(c) begin wc = 0; while (!(c) && wc < 300) begin @(negedge CLK_SYS); wc++; end \
  if (!(c)) begin error_cnt++; $display("ERROR wait exp 1 got 0"); end end

////////////////////////////////////////////////////////////////////////////////
module tb_top
  import pbq_pkg::*;
;
  localparam logic [4:0] AL = 5'h10, EQ = 5'h08, RL = 5'h04, RP = 5'h02, TA = 5'h01;
  logic CLK_SYS = 1'b0;
  logic RESET = 1'b1;
  pbq_cmd_t cmd = '0;
  pbq_rxend_t rxe = '0;
  pbq_txdone_t txd;
  logic [PNW-1:0] pns = '0;
  logic txen = 0, receive_enable_bit = 0, autor = 0, rxie = 0, rxv = 0, rxst = 0, fatal = 0, dok = 1;
  logic [FREEW-1:0] resv = '0;
  logic [DATAW-1:0] rxd = '0;
  logic ade, txs, txstop, tqe, tdf, cqe, rpf, rint, rdy, we;
  logic [PNW-1:0] ares, txp, tdp, rhp, p;
  logic [FREEW-1:0] fp, msz;
  logic [ADDRW-1:0] ma;
  logic [DATAW-1:0] md;
  logic [ADDRW+DATAW-1:0] wq[$];
  int error_cnt = 0;
  int checks = 0;
  int wc = 0;
  int nst = 0;

  always #10 CLK_SYS = ~CLK_SYS;

  pbq_top #(.RX_FIFO_DEPTH(32)) dut (.CLK_SYS(CLK_SYS), .RESET(RESET), .CE(1'b1),
    .HOST_CMD(cmd), .PACKET_NUMBER_SELECT(pns), .TRANSMIT_ENABLE_BIT(txen),
    .RECEIVE_ENABLE_BIT(receive_enable_bit), .AUTO_RELEASE(autor), .RX_INT_ENABLE(rxie),
    .RESERVED_PAGES(resv), .TX_DEFER_OK(dok), .TX_DONE(txd), .RX_FRAME_START(rxst),
    .RX_DATA_VALID(rxv), .RX_DATA(rxd), .RX_DATA_READY(rdy), .RX_END(rxe),
    .ALLOCATION_DONE_FLAG(ade), .ALLOC_RESULT(ares), .TX_START(txs), .TX_PKT(txp),
    .TX_STOPPED(txstop), .TX_QUEUE_EMPTY(tqe), .TX_DONE_FLAG(tdf),
    .COMPLETION_QUEUE_EMPTY(cqe), .TX_DONE_PKT(tdp), .RX_PENDING_FLAG(rpf),
    .RX_HEAD_PKT(rhp), .RX_INT(rint), .FREE_PAGES(fp), .MEM_SIZE_PAGES(msz),
    .MEM_WE(we), .MEM_ADDR(ma), .MEM_WDATA(md));

  pbq_mac_model #(.DLY(5)) mac (.clk(CLK_SYS), .rst(RESET), .tx_start(txs),
    .fatal(fatal), .tx_done(txd));

  always @(posedge CLK_SYS) begin
    if (we === 1'b1) wq.push_back({ma, md});
    if (txs === 1'b1) nst++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task hc(input logic [4:0] s, input logic [BCW-1:0] b);
    @(negedge CLK_SYS);
    cmd = {s, b};
    @(negedge CLK_SYS);
    cmd = '0;
  endtask

  task rx_frame(input logic ok, input int n);
    @(negedge CLK_SYS);
    rxst = 1;
    @(negedge CLK_SYS);
    rxst = 0;
    rxv = 1;
    for (int i = 0; i < n; i++) begin
      rxd = 32'hc0de0000 + i;
      do @(posedge CLK_SYS); while (rdy !== 1'b1);
      @(negedge CLK_SYS);
    end
    rxv = 0;
    rxe = '{1'b1, ok, 16'h0b0b, 12'h00c};
    @(negedge CLK_SYS);
    rxe = '0;
  endtask

  task tdone(input string s);
    $display("Test %s finished, errors so far %0d", s, error_cnt);
  endtask

  task close_out;
    $display("Checks %0d, errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #(20 * 20000);
    error_cnt++;
    close_out;
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(negedge CLK_SYS);
    RESET = 0;
    `CHK("tqe", 1'b1, tqe)
    `CHK("cqe", 1'b1, cqe)
    `CHK("free", 7'h40, fp)
    `CHK("size", 7'h40, msz)
    tdone("reset");
    hc(AL, 12'h12c);
    `WAITF(ade === 1'b1)
    `CHK("ares", 4'h0, ares)
    `CHK("free", 7'h3e, fp)
    hc(AL, 12'h000);
    `WAITF(ade === 1'b1)
    `CHK("ares", 4'h1, ares)
    `CHK("free", 7'h3d, fp)
    pns = 0;
    hc(EQ, 12'h0);
    `CHK("tqe", 1'b0, tqe)
    repeat (5) @(negedge CLK_SYS);
    `CHK("nst", 0, nst)
    dok = 0;
    txen = 1;
    repeat (5) @(negedge CLK_SYS);
    `CHK("nst", 0, nst)
    dok = 1;
    `WAITF(tdf === 1'b1)
    @(negedge CLK_SYS);
    `CHK("nst", 1, nst)
    `CHK("txp", 4'h0, txp)
    `CHK("tqe", 1'b1, tqe)
    `CHK("wr", {13'h0000, 16'h5a5a}, {wq[0][44:32], wq[0][15:0]})
    `CHK("cqe", 1'b0, cqe)
    `CHK("tdp", 4'h0, tdp)
    hc(TA, 12'h0);
    `CHK("tdf", 1'b0, tdf)
    hc(RL, 12'h0);
    `CHK("free", 7'h3f, fp)
    tdone("tx");
    autor = 1;
    pns = 1;
    wq.delete();
    hc(EQ, 12'h0);
    repeat (15) @(negedge CLK_SYS);
    `CHK("cqe", 1'b1, cqe)
    `CHK("free", 7'h40, fp)
    `CHK("wq", 0, wq.size())
    hc(AL, 12'h0);
    `WAITF(ade === 1'b1)
    fatal = 1;
    pns = ares;
    hc(EQ, 12'h0);
    `WAITF(tdf === 1'b1)
    `CHK("stop", 1'b1, txstop)
    hc(TA, 12'h0);
    hc(RL, 12'h0);
    txen = 0;
    fatal = 0;
    tdone("auto");
    receive_enable_bit = 1;
    rxie = 1;
    wq.delete();
    rx_frame(1, 3);
    `WAITF(rpf === 1'b1)
    @(negedge CLK_SYS);
    p = 4'h0;
    `CHK("wq", 5, wq.size())
    for (int i = 0; i < 3; i++) begin
      `CHK("dat", {p, 9'h002 + 9'(i), 32'hc0de0000 + i}, wq[i])
    end
    `CHK("st", {p, 9'h000, 16'h0b0b}, {wq[3][44:32], wq[3][15:0]})
    `CHK("cnt", {p, 9'h001, 12'h00c}, {wq[4][44:32], wq[4][11:0]})
    `CHK("rhp", p, rhp)
    `CHK("free", 7'h3f, fp)
    `CHK("rint", 1'b1, rint)
    rxie = 0;
    @(negedge CLK_SYS);
    `CHK("rint", 1'b0, rint)
    hc(RP, 12'h0);
    `CHK("rpf", 1'b0, rpf)
    `CHK("free", 7'h40, fp)
    rx_frame(0, 3);
    repeat (15) @(negedge CLK_SYS);
    `CHK("rpf", 1'b0, rpf)
    `CHK("free", 7'h40, fp)
    for (int i = 0; i < 8; i++) begin
      hc(AL, (i < 7) ? 12'h800 : 12'h700);
      `WAITF(ade === 1'b1)
    end
    `CHK("free", 7'h01, fp)
    rx_frame(1, 70);
    repeat (15) @(negedge CLK_SYS);
    `CHK("free", 7'h01, fp)
    `CHK("rpf", 1'b0, rpf)
    hc(AL, 12'h200);
    repeat (5) @(negedge CLK_SYS);
    `CHK("ade", 1'b0, ade)
    for (int i = 0; i < 8; i++) begin
      pns = 4'(i);
      hc(RL, 12'h0);
    end
    `CHK("ade", 1'b1, ade)
    `CHK("ares", 4'h0, ares)
    `CHK("free", 7'h3e, fp)
    pns = 0;
    hc(RL, 12'h0);
    `CHK("free", 7'h40, fp)
    tdone("overrun");
    resv = 7'h40;
    wq.delete();
    rx_frame(1, 3);
    repeat (15) @(negedge CLK_SYS);
    `CHK("wq", 0, wq.size())
    `CHK("rpf", 1'b0, rpf)
    tdone("rx");
    close_out;
  end
endmodule

// ### hdl/pbq_top.sv
// Packet buffer queue manager: page accounting, packet queues and receive data path
//
// Summary of operation
// - Host allocate reserves memory, sets done flag
// - Enqueue pushes selected packet onto transmit queue
// - Transmit starts only when enabled and deferral allows
// - Status written to word zero in the same cycle as the completion queue push
// - Transmit done while completion queue non-empty
// - Completion queue head readable in done order
// - Acknowledge pops completion queue head
// - Release frees selected packet pages and number
// - Receive allocates a packet, grows page by page
// - Sequential receive offsets map to physical addresses
// - Overrun drops frame and frees its memory
// - Status word zero, byte count word one
// - Good CRC pushes receive queue, pending flag
// - Bad CRC frees packet, no receive interrupt
// - Receive interrupt: queue non-empty and enabled
// - Receive pop removes head and frees it
// - Free at or below reserve blocks receive allocation
// - Frames in progress finish despite raised reserve
// - Transmit queue empty flag tracks queue
// - Auto release frees good packets, skips completion
// - Auto release fatal error stops, raises done
// - Done flag is inverse of completion empty
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module pbq_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32,
  parameter int AW = $clog2(DEPTH),
  parameter int CW = $clog2(DEPTH + 1)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic clr,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [CW-1:0] count
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } pbq_fst_t;

  pbq_fst_t f_reg;
  pbq_fst_t f_next;
  logic push;
  logic pop;

  assign in_ready = f_reg.cnt != CW'(DEPTH);
  assign out_valid = f_reg.cnt != '0;
  assign out_data = f_reg.mem[f_reg.rp];
  assign count = f_reg.cnt;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    f_next = f_reg;
    if (push) begin
      f_next.mem[f_reg.wp] = in_data;
      f_next.wp = AW'(f_reg.wp + 1'b1);
    end
    if (pop) begin
      f_next.rp = AW'(f_reg.rp + 1'b1);
    end
    if (push && !pop) begin
      f_next.cnt = CW'(f_reg.cnt + 1'b1);
    end else if (pop && !push) begin
      f_next.cnt = CW'(f_reg.cnt - 1'b1);
    end
    if (clr) begin
      f_next.wp = '0;
      f_next.rp = '0;
      f_next.cnt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      f_reg <= '0;
    end else if (ce) begin
      f_reg <= f_next;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module pbq_top
  import pbq_pkg::*;
#(
  parameter int RX_FIFO_DEPTH = RXF_DEPTH
) (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic CE,
  input wire pbq_cmd_t HOST_CMD,
  input wire logic [PNW-1:0] PACKET_NUMBER_SELECT,
  input wire logic TRANSMIT_ENABLE_BIT,
  input wire logic RECEIVE_ENABLE_BIT,
  input wire logic AUTO_RELEASE,
  input wire logic RX_INT_ENABLE,
  input wire logic [FREEW-1:0] RESERVED_PAGES,
  input wire logic TX_DEFER_OK,
  input wire pbq_txdone_t TX_DONE,
  input wire logic RX_FRAME_START,
  input wire logic RX_DATA_VALID,
  input wire logic [DATAW-1:0] RX_DATA,
  output logic RX_DATA_READY,
  input wire pbq_rxend_t RX_END,
  output logic ALLOCATION_DONE_FLAG,
  output logic [PNW-1:0] ALLOC_RESULT,
  output logic TX_START,
  output logic [PNW-1:0] TX_PKT,
  output logic TX_STOPPED,
  output logic TX_QUEUE_EMPTY,
  output logic TX_DONE_FLAG,
  output logic COMPLETION_QUEUE_EMPTY,
  output logic [PNW-1:0] TX_DONE_PKT,
  output logic RX_PENDING_FLAG,
  output logic [PNW-1:0] RX_HEAD_PKT,
  output logic RX_INT,
  output logic [FREEW-1:0] FREE_PAGES,
  output logic [FREEW-1:0] MEM_SIZE_PAGES,
  output logic MEM_WE,
  output logic [ADDRW-1:0] MEM_ADDR,
  output logic [DATAW-1:0] MEM_WDATA
);
  localparam int QCW = $clog2(N_PKT + 1);

  typedef struct packed {
    logic [N_PKT-1:0] used;
    logic [N_PKT-1:0][PGW-1:0] pages;
    logic [FREEW-1:0] free;
    logic alloc_pend;
    logic [PGW-1:0] alloc_need;
    logic alloc_done;
    logic [PNW-1:0] alloc_pkt;
    logic tx_busy;
    logic [PNW-1:0] tx_pkt;
    logic tx_start;
    logic tx_stop;
    logic tx_wr_pend;
    logic [STATW-1:0] tx_wr_stat;
    logic [PNW-1:0] tx_wr_pkt;
    pbq_rxst_t rx_st;
    logic [PNW-1:0] rx_pkt;
    logic [OFFW:0] rx_off;
    logic [STATW-1:0] rx_stat;
    logic [BCW-1:0] rx_bytes;
    logic rx_crc;
    logic rx_flush;
    logic mem_we;
    logic [ADDRW-1:0] mem_addr;
    logic [DATAW-1:0] mem_wdata;
  } pbq_state_t;

  localparam pbq_state_t ST_RST = '{free: FREE_RST, rx_st: RX_IDLE, default: '0};

  pbq_state_t s_reg;
  pbq_state_t s_next;
  logic tq_in_ready, tq_valid, tq_pop;
  logic [PNW-1:0] tq_head;
  logic cq_push, cq_valid, cq_pop;
  logic [QCW-1:0] cq_count;
  logic rq_push, rq_valid, rq_pop;
  logic rxf_in_valid, rxf_in_ready, rxf_valid, rxf_pop;
  logic [DATAW-1:0] rxf_data;

  // Lowest unused packet number, with a found bit on top
  function automatic logic [PNW:0] first_free(input logic [N_PKT-1:0] u);
    logic [PNW:0] r;
    r = '0;
    for (int i = N_PKT - 1; i >= 0; i--) begin
      if (!u[i]) begin
        r = {1'b1, PNW'(i)};
      end
    end
    return r;
  endfunction

  // Return a packet's pages and number to the pool
  function automatic pbq_state_t rel_pkt(input pbq_state_t x, input logic [PNW-1:0] p);
    pbq_state_t y;
    y = x;
    if (x.used[p]) begin
      y.used[p] = 1'b0;
      y.free = FREEW'(x.free + FREEW'(x.pages[p]));
      y.pages[p] = '0;
    end
    return y;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Packet number queues and receive data buffer
  // Enqueue into transmit queue
  pbq_fifo #(.WIDTH(PNW), .DEPTH(N_PKT)) u_txq (
    .clk(CLK_SYS), .rst(RESET), .ce(CE), .clr(1'b0),
    .in_valid(HOST_CMD.enqueue), .in_ready(tq_in_ready), .in_data(PACKET_NUMBER_SELECT),
    .out_valid(tq_valid), .out_ready(tq_pop), .out_data(tq_head), .count()
  );
  pbq_fifo #(.WIDTH(PNW), .DEPTH(N_PKT)) u_cq (
    .clk(CLK_SYS), .rst(RESET), .ce(CE), .clr(1'b0),
    .in_valid(cq_push), .in_ready(), .in_data(s_reg.tx_wr_pkt),
    .out_valid(cq_valid), .out_ready(cq_pop), .out_data(TX_DONE_PKT), .count(cq_count)
  );
  pbq_fifo #(.WIDTH(PNW), .DEPTH(N_PKT)) u_rq (
    .clk(CLK_SYS), .rst(RESET), .ce(CE), .clr(1'b0),
    .in_valid(rq_push), .in_ready(), .in_data(s_reg.rx_pkt),
    .out_valid(rq_valid), .out_ready(rq_pop), .out_data(RX_HEAD_PKT), .count()
  );
  pbq_fifo #(.WIDTH(DATAW), .DEPTH(RX_FIFO_DEPTH)) u_rxf (
    .clk(CLK_SYS), .rst(RESET), .ce(CE), .clr(s_reg.rx_flush),
    .in_valid(rxf_in_valid), .in_ready(rxf_in_ready), .in_data(RX_DATA),
    .out_valid(rxf_valid), .out_ready(rxf_pop), .out_data(rxf_data), .count()
  );

  assign rxf_in_valid = RX_DATA_VALID && s_reg.rx_st == RX_RECV;
  assign RX_DATA_READY = (s_reg.rx_st == RX_RECV) ? rxf_in_ready :
                         (s_reg.rx_st == RX_IDLE || s_reg.rx_st == RX_DROP);

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [PNW:0] ff;
    logic [BCW:0] bsum;
    logic [BCW-PAGE_SHIFT:0] pg;
    logic mem_busy;
    logic drain;
    s_next = s_reg;
    ff = '0;
    bsum = '0;
    pg = '0;
    mem_busy = 1'b0;
    drain = 1'b0;
    tq_pop = 1'b0;
    cq_push = 1'b0;
    cq_pop = 1'b0;
    rq_push = 1'b0;
    rq_pop = 1'b0;
    rxf_pop = 1'b0;
    s_next.mem_we = 1'b0;
    s_next.tx_start = 1'b0;
    s_next.rx_flush = 1'b0;
    if (HOST_CMD.alloc) begin
      bsum = {1'b0, HOST_CMD.alloc_bytes} + (BCW + 1)'(PAGE_BYTES - 1);
      pg = bsum[BCW:PAGE_SHIFT];
      if (pg == '0) begin
        pg = (BCW - PAGE_SHIFT + 1)'(1);
      end else if (pg > (BCW - PAGE_SHIFT + 1)'(MAX_PKT_PAGES)) begin
        pg = (BCW - PAGE_SHIFT + 1)'(MAX_PKT_PAGES);
      end
      s_next.alloc_pend = 1'b1;
      s_next.alloc_done = 1'b0;
      s_next.alloc_need = PGW'(pg);
    end else if (s_reg.alloc_pend) begin
      ff = first_free(s_next.used);
      if (ff[PNW] && s_next.free >= FREEW'(s_reg.alloc_need)) begin
        s_next.used[ff[PNW-1:0]] = 1'b1;
        s_next.pages[ff[PNW-1:0]] = s_reg.alloc_need;
        s_next.free = FREEW'(s_next.free - FREEW'(s_reg.alloc_need));
        s_next.alloc_pend = 1'b0;
        s_next.alloc_done = 1'b1;
        s_next.alloc_pkt = ff[PNW-1:0];
      end
    end
    if (HOST_CMD.release_pkt) begin
      s_next = rel_pkt(s_next, PACKET_NUMBER_SELECT);
    end
    // Pop receive head and free it
    if (HOST_CMD.rx_pop && rq_valid) begin
      rq_pop = 1'b1;
      s_next = rel_pkt(s_next, RX_HEAD_PKT);
    end
    cq_pop = HOST_CMD.tx_ack && cq_valid;
    // Stopped transmit resumes after enable drops
    if (s_reg.tx_stop && !TRANSMIT_ENABLE_BIT) begin
      s_next.tx_stop = 1'b0;
    end
    if (!s_reg.tx_busy && !s_reg.tx_stop && tq_valid && TRANSMIT_ENABLE_BIT && TX_DEFER_OK) begin
      tq_pop = 1'b1;
      s_next.tx_busy = 1'b1;
      s_next.tx_pkt = tq_head;
      s_next.tx_start = 1'b1;
    end
    if (s_reg.tx_busy && TX_DONE.valid) begin
      s_next.tx_busy = 1'b0;
      if (AUTO_RELEASE && !TX_DONE.fatal) begin
        // Good packet freed without completion entry
        s_next = rel_pkt(s_next, s_reg.tx_pkt);
      end else begin
        s_next.tx_wr_pend = 1'b1;
        s_next.tx_wr_stat = TX_DONE.status;
        s_next.tx_wr_pkt = s_reg.tx_pkt;
        // Fatal error under auto release halts
        s_next.tx_stop = AUTO_RELEASE;
      end
    end
    // Status to word zero and completion queue push in the same cycle
    if (s_reg.tx_wr_pend) begin
      mem_busy = 1'b1;
      cq_push = 1'b1;
      s_next.tx_wr_pend = 1'b0;
      s_next.mem_we = 1'b1;
      s_next.mem_addr = {s_reg.tx_wr_pkt, STAT_OFF};
      s_next.mem_wdata = DATAW'(s_reg.tx_wr_stat);
    end
    case (s_reg.rx_st)
      RX_IDLE: begin
        if (RX_FRAME_START && RECEIVE_ENABLE_BIT) begin
          ff = first_free(s_next.used);
          // New frame needs free memory above reserve
          if (ff[PNW] && s_next.free > RESERVED_PAGES) begin
            s_next.used[ff[PNW-1:0]] = 1'b1;
            s_next.pages[ff[PNW-1:0]] = PGW'(1);
            s_next.free = FREEW'(s_next.free - 1'b1);
            s_next.rx_pkt = ff[PNW-1:0];
            s_next.rx_off = DATA_START;
            s_next.rx_st = RX_RECV;
          end else begin
            s_next.rx_st = RX_DROP;
          end
        end
      end
      RX_RECV: begin
        drain = 1'b1;
        if (RX_END.valid) begin
          s_next.rx_stat = RX_END.status;
          s_next.rx_bytes = RX_END.bytes;
          s_next.rx_crc = RX_END.crc_ok;
          s_next.rx_st = RX_DRAIN;
        end
      end
      RX_DRAIN: begin
        drain = 1'b1;
        if (!rxf_valid) begin
          s_next.rx_st = RX_WSTAT;
        end
      end
      RX_WSTAT: begin
        if (!mem_busy) begin
          s_next.mem_we = 1'b1;
          s_next.mem_addr = {s_reg.rx_pkt, STAT_OFF};
          s_next.mem_wdata = DATAW'(s_reg.rx_stat);
          s_next.rx_st = RX_WCNT;
        end
      end
      RX_WCNT: begin
        if (!mem_busy) begin
          s_next.mem_we = 1'b1;
          s_next.mem_addr = {s_reg.rx_pkt, COUNT_OFF};
          s_next.mem_wdata = DATAW'(s_reg.rx_bytes);
          s_next.rx_st = RX_IDLE;
          if (s_reg.rx_crc) begin
            rq_push = 1'b1;
          end else begin
            s_next = rel_pkt(s_next, s_reg.rx_pkt);
          end
        end
      end
      RX_DROP: begin
        if (RX_END.valid) begin
          s_next.rx_st = RX_IDLE;
        end
      end
      default: begin
        s_next.rx_st = RX_IDLE;
      end
    endcase
    if (drain && !mem_busy && rxf_valid) begin
      if ({1'b0, s_reg.rx_off[OFFW:WORD_SHIFT]} >= s_next.pages[s_reg.rx_pkt]) begin
        // Frames in progress ignore the reserve
        if (s_next.pages[s_reg.rx_pkt] != PGW'(MAX_PKT_PAGES) && s_next.free != '0) begin
          s_next.pages[s_reg.rx_pkt] = PGW'(s_next.pages[s_reg.rx_pkt] + 1'b1);
          s_next.free = FREEW'(s_next.free - 1'b1);
        end else begin
          // Overrun drops frame and its memory
          s_next = rel_pkt(s_next, s_reg.rx_pkt);
          s_next.rx_flush = 1'b1;
          s_next.rx_st = (s_reg.rx_st == RX_RECV && !RX_END.valid) ? RX_DROP : RX_IDLE;
        end
      end
      if (!s_next.rx_flush) begin
        rxf_pop = 1'b1;
        s_next.mem_we = 1'b1;
        s_next.mem_addr = {s_reg.rx_pkt, s_reg.rx_off[OFFW-1:0]};
        s_next.mem_wdata = rxf_data;
        s_next.rx_off = (OFFW + 1)'(s_reg.rx_off + 1'b1);
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      s_reg <= ST_RST;
    end else if (CE) begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign ALLOCATION_DONE_FLAG = s_reg.alloc_done;
  assign ALLOC_RESULT = s_reg.alloc_pkt;
  assign TX_START = s_reg.tx_start;
  assign TX_PKT = s_reg.tx_pkt;
  assign TX_STOPPED = s_reg.tx_stop;
  assign TX_QUEUE_EMPTY = !tq_valid;
  // Done flag inverse of completion empty
  assign COMPLETION_QUEUE_EMPTY = !cq_valid;
  assign TX_DONE_FLAG = cq_valid;
  assign RX_PENDING_FLAG = rq_valid;
  assign RX_INT = rq_valid && RX_INT_ENABLE;
  assign FREE_PAGES = s_reg.free;
  assign MEM_SIZE_PAGES = FREEW'(MEM_PAGES);
  assign MEM_WE = s_reg.mem_we;
  assign MEM_ADDR = s_reg.mem_addr;
  assign MEM_WDATA = s_reg.mem_wdata;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET || !CE);

  alloc_grant_a: assert property ($rose(ALLOCATION_DONE_FLAG) |->
    $past(s_reg.free) >= FREEW'($past(s_reg.alloc_need))) else $error("alloc beyond free");
  alloc_result_a: assert property ($rose(ALLOCATION_DONE_FLAG) |->
    s_reg.used[ALLOC_RESULT]) else $error("alloc result not in use");
  enqueue_push_a: assert property (HOST_CMD.enqueue && tq_in_ready |=>
    !TX_QUEUE_EMPTY) else $error("enqueue lost");
  tx_start_gate_a: assert property (TX_START |->
    $past(TRANSMIT_ENABLE_BIT) && $past(TX_DEFER_OK)) else $error("start not permitted");
  tx_status_wr_a: assert property (s_reg.tx_busy && TX_DONE.valid &&
    !(AUTO_RELEASE && !TX_DONE.fatal) |=> ##1 MEM_WE && MEM_ADDR[OFFW-1:0] == STAT_OFF &&
    MEM_ADDR[ADDRW-1:OFFW] == $past(s_reg.tx_pkt, 2) && TX_DONE_FLAG)
    else $error("tx status not written");
  ack_pop_a: assert property (HOST_CMD.tx_ack && TX_DONE_FLAG && !s_reg.tx_wr_pend |=>
    cq_count == QCW'($past(cq_count) - 1'b1)) else $error("ack did not pop");
  rx_good_push_a: assert property (s_reg.rx_st == RX_WCNT && s_reg.rx_crc &&
    !s_reg.tx_wr_pend |=> RX_PENDING_FLAG) else $error("good frame not queued");
  rx_bad_free_a: assert property (s_reg.rx_st == RX_WCNT && !s_reg.rx_crc &&
    !s_reg.tx_wr_pend |=> !s_reg.used[$past(s_reg.rx_pkt)] && $stable(RX_PENDING_FLAG))
    else $error("bad frame kept");
  rx_reserve_a: assert property (s_reg.rx_st == RX_IDLE && RX_FRAME_START &&
    RECEIVE_ENABLE_BIT && s_reg.free <= RESERVED_PAGES |=> s_reg.rx_st == RX_DROP)
    else $error("frame accepted under reserve");
  auto_rel_a: assert property (s_reg.tx_busy && TX_DONE.valid && AUTO_RELEASE &&
    !TX_DONE.fatal |=> !s_reg.tx_wr_pend && !s_reg.used[$past(s_reg.tx_pkt)])
    else $error("auto release failed");
  fatal_stop_a: assert property (s_reg.tx_busy && TX_DONE.valid && AUTO_RELEASE &&
    TX_DONE.fatal |=> TX_STOPPED ##1 TX_DONE_FLAG) else $error("fatal did not stop");
  rx_int_a: assert property (RX_INT |-> RX_PENDING_FLAG && RX_INT_ENABLE)
    else $error("receive interrupt without cause");
  free_bound_a: assert property (FREE_PAGES <= MEM_SIZE_PAGES)
    else $error("free pages exceed size");

  tx_round_c: cover property (TX_START ##[1:50] TX_DONE_FLAG);
  rx_good_c: cover property (s_reg.rx_st == RX_RECV ##[1:200] RX_PENDING_FLAG);
  rx_drop_c: cover property (s_reg.rx_st == RX_DROP);
  rxf_full_c: cover property (!rxf_in_ready);
endmodule

// ### include/pbq_pkg.sv
// Shared constants, carrier structs and state codes for the packet buffer queue manager
package pbq_pkg;
  localparam int PNW = 4;
  localparam int N_PKT = 16;
  localparam int PGW = 4;
  localparam int MAX_PKT_PAGES = 8;
  localparam int WORD_SHIFT = 6;
  localparam int PAGE_SHIFT = 8;
  localparam int PAGE_BYTES = 256;
  localparam int OFFW = 9;
  localparam int ADDRW = PNW + OFFW;
  localparam int DATAW = 32;
  localparam int BCW = 12;
  localparam int STATW = 16;
  localparam int FREEW = 7;
  localparam int MEM_PAGES = 64;
  localparam int RXF_DEPTH = 32;
  localparam logic [FREEW-1:0] FREE_RST = 7'h40;
  localparam logic [OFFW-1:0] STAT_OFF = 9'h000;
  localparam logic [OFFW-1:0] COUNT_OFF = 9'h001;
  localparam logic [OFFW:0] DATA_START = 10'h002;

  // Host command strobes, one cycle each
  typedef struct packed {
    logic alloc;
    logic enqueue;
    logic release_pkt;
    logic rx_pop;
    logic tx_ack;
    logic [BCW-1:0] alloc_bytes;
  } pbq_cmd_t;

  // Completion report from the transmit engine
  typedef struct packed {
    logic valid;
    logic fatal;
    logic [STATW-1:0] status;
  } pbq_txdone_t;

  // End of frame report from the receive engine
  typedef struct packed {
    logic valid;
    logic crc_ok;
    logic [STATW-1:0] status;
    logic [BCW-1:0] bytes;
  } pbq_rxend_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'h0,
    RX_RECV = 3'h1,
    RX_DRAIN = 3'h2,
    RX_WSTAT = 3'h3,
    RX_WCNT = 3'h4,
    RX_DROP = 3'h5
  } pbq_rxst_t;
endpackage
